/* File: rtl/pmt_pkg.sv */
// package for the 8-bit period match timer: offsets, fields, reset values, types
// Summary of operation
// - control bits 6..3 pick postscale n+1
// - control bit 2 runs or stops timer
// - control bits 1..0 prescale 1, 4, 16
// - control bit 7 reads zero; rest reset zero
// - period register read/write, resets to all ones
// - count register read/write, resets to zero
// - prescaler clocked by instruction clock, advances count
// - count equals period: wrap to zero, postscaler advances
// - postscaler output sets match interrupt flag
// - count/control writes and reset clear scalers
package pmt_pkg;
   // register offsets (byte addresses on the plain port)
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_PERIOD = 4'h4;
   localparam logic [3:0] ADDR_COUNT = 4'h8;
   localparam logic [3:0] ADDR_IRQ_ENABLE = 4'hC;
   localparam logic [3:0] ADDR_IRQ_FLAGS = 4'h1;
   localparam logic [3:0] ADDR_CORE_IRQ = 4'h2;
   // control field positions
   localparam int CTL_POST_LSB = 3;
   localparam int CTL_RUN_BIT = 2;
   localparam int CTL_PRE_LSB = 0;
   // bit positions of the match enable/flag and the irq gates
   localparam int MATCH_BIT = 1;
   localparam int GLOBAL_GATE_BIT = 7;
   localparam int PERIPH_GATE_BIT = 6;
   // reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] PERIOD_RESET = 8'hFF;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] IRQ_RESET = 8'h00;
   localparam logic [6:0] CONTROL_MASK = 7'h7F;
   // timing: instruction clock is the system clock divided by four
   localparam int INSTR_DIV = 4;
   localparam logic [1:0] INSTR_LAST = 2'h3;
   localparam logic [3:0] PRE_LAST_4 = 4'h3;
   localparam logic [3:0] PRE_LAST_16 = 4'hF;
   // prescale codes
   localparam logic [1:0] PRE_DIV1 = 2'h0;
   localparam logic [1:0] PRE_DIV4 = 2'h1;
   // register access bundle, write and read strobes
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] data;
      logic wr;
      logic rd;
   } pmt_bus_t;
endpackage : pmt_pkg

/* File: rtl/pmt_timer.sv */
// 8-bit period match timer with prescaler, postscaler and match interrupt
`timescale 1ns/10ps
module pmt_timer
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   output logic irq_out,
   output logic match_pulse_out
);
   pmt_pkg::pmt_bus_t bus;
   logic [6:0] control_reg;
   logic [7:0] period_reg;
   logic [7:0] count_reg;
   logic [7:0] irq_enable_reg;
   logic [7:0] irq_flags_reg;
   logic [7:0] core_irq_reg;
   logic [1:0] instr_div_reg;
   logic [3:0] pre_cnt_reg;
   logic [3:0] post_cnt_reg;
   logic [3:0] pre_last;
   logic instr_tick;
   logic pre_tick;
   logic match;
   logic post_fire;
   logic wr_control;
   logic wr_count;
   logic scaler_clear;

   assign bus = '{addr: addr_in, data: wdata_in, wr: wr_in, rd: rd_in};
   assign wr_control = bus.wr && (bus.addr == pmt_pkg::ADDR_CONTROL);
   assign wr_count = bus.wr && (bus.addr == pmt_pkg::ADDR_COUNT);
   // scalers clear on count or control writes; reset handled in each process
   assign scaler_clear = wr_control || wr_count;

   // control register; bit 7 is not stored so it reads zero
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
         control_reg <= pmt_pkg::CONTROL_RESET[6:0];
      else if (wr_control)
         control_reg <= bus.data[6:0] & pmt_pkg::CONTROL_MASK;
   end

   // control writes land as written and never disturb the running count
   ctl_write_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      wr_control |=> control_reg == $past(bus.data[6:0]))
      else $error("control write did not land");
   ctl_keep_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      wr_control && !pre_tick |=> $stable(count_reg))
      else $error("control write changed count");

   // period register
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
         period_reg <= pmt_pkg::PERIOD_RESET;
      else if (bus.wr && (bus.addr == pmt_pkg::ADDR_PERIOD))
         period_reg <= bus.data;
   end

   // period write and reset values of period and count
   period_write_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      bus.wr && bus.addr == pmt_pkg::ADDR_PERIOD |=> period_reg == $past(bus.data))
      else $error("period write did not land");
   period_rst_a: assert property (
      @(posedge clock_in)
      sys_rst_in |=> period_reg == pmt_pkg::PERIOD_RESET && count_reg == pmt_pkg::COUNT_RESET)
      else $error("reset values wrong");

   // instruction clock enable: one pulse every four system clocks
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
         instr_div_reg <= 2'h0;
      else
         instr_div_reg <= instr_div_reg + 2'h1;
   end
   assign instr_tick = (instr_div_reg == pmt_pkg::INSTR_LAST);

   // the divider is free running and not cleared by writes, so the first
   // increment after a control write may come up to three clocks early
   instr_rate_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      instr_tick |=> !instr_tick [*3] ##1 instr_tick)
      else $error("instruction tick not every four cycles");

   // prescaler: limit from the select field, upper bit set means 16
   always_comb
   begin
      if (control_reg[pmt_pkg::CTL_PRE_LSB + 1])
         pre_last = pmt_pkg::PRE_LAST_16;
      else if (control_reg[pmt_pkg::CTL_PRE_LSB +: 2] == pmt_pkg::PRE_DIV4)
         pre_last = pmt_pkg::PRE_LAST_4;
      else
         pre_last = 4'h0;
   end

   // each prescale code releases a tick only at its own terminal count
   div1_rate_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      control_reg[2:0] == 3'h4 && !bus.wr && instr_tick |-> pre_tick)
      else $error("divide by one missed a tick");
   div4_tick_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      control_reg[pmt_pkg::CTL_PRE_LSB +: 2] == pmt_pkg::PRE_DIV4 && pre_tick |-> pre_cnt_reg == pmt_pkg::PRE_LAST_4)
      else $error("divide by four ticked early");
   div16_tick_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      control_reg[pmt_pkg::CTL_PRE_LSB + 1] && pre_tick |-> pre_cnt_reg == pmt_pkg::PRE_LAST_16)
      else $error("divide by sixteen ticked early");
   pre_range_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      pre_cnt_reg <= pre_last)
      else $error("prescaler past its limit");

   // prescaler counts instruction ticks only while the run bit is set
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in || scaler_clear)
         pre_cnt_reg <= 4'h0;
      else if (instr_tick && control_reg[pmt_pkg::CTL_RUN_BIT])
         pre_cnt_reg <= (pre_cnt_reg >= pre_last) ? 4'h0 : pre_cnt_reg + 4'h1;
   end
   assign pre_tick = instr_tick && control_reg[pmt_pkg::CTL_RUN_BIT] && !scaler_clear
                     && (pre_cnt_reg >= pre_last);

   // masking the tick with the clear keeps a write and an increment apart
   pre_hold_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      !control_reg[pmt_pkg::CTL_RUN_BIT] && !scaler_clear |=> $stable(pre_cnt_reg))
      else $error("prescaler moved while stopped");
   scaler_clr_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      scaler_clear |=> pre_cnt_reg == 4'h0 && post_cnt_reg == 4'h0)
      else $error("scalers not cleared on write");
   rst_clear_a: assert property (
      @(posedge clock_in)
      sys_rst_in |=> pre_cnt_reg == 4'h0 && post_cnt_reg == 4'h0 && control_reg == 7'h00)
      else $error("reset did not clear scalers");

   // comparator runs all the time; a match wraps count on next increment
   assign match = (count_reg == period_reg);

   // count register; a control write leaves it alone
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
         count_reg <= pmt_pkg::COUNT_RESET;
      else if (wr_count)
         count_reg <= bus.data;
      else if (pre_tick)
         count_reg <= match ? 8'h00 : count_reg + 8'h01;
   end

   // count steps by one, wraps after a match and holds while stopped;
   // a count above the period runs on to the 8-bit rollover first
   count_wrap_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      pre_tick && match && !wr_count |=> count_reg == 8'h00)
      else $error("count did not wrap after match");
   count_step_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      pre_tick && !match |=> count_reg == $past(count_reg) + 8'h01)
      else $error("count did not step by one");
   count_write_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      wr_count |=> count_reg == $past(bus.data))
      else $error("count write did not land");
   stop_hold_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      !control_reg[pmt_pkg::CTL_RUN_BIT] && !bus.wr |=> $stable(count_reg))
      else $error("count moved while stopped");

   // postscaler: fires on the (n+1)th match increment
   assign post_fire = pre_tick && match && (post_cnt_reg == control_reg[pmt_pkg::CTL_POST_LSB +: 4]);
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in || scaler_clear)
         post_cnt_reg <= 4'h0;
      else if (pre_tick && match)
         post_cnt_reg <= post_fire ? 4'h0 : post_cnt_reg + 4'h1;
   end
   assign match_pulse_out = post_fire;

   // postscaler fires on every match at 1:1 and never runs past its select
   post_one_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      control_reg[6:3] == 4'h0 && pre_tick && match |-> post_fire)
      else $error("1:1 postscale missed a match");
   post_range_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      post_cnt_reg <= control_reg[pmt_pkg::CTL_POST_LSB +: 4])
      else $error("postscaler past its select");
   post_step_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      pre_tick && match && !post_fire |=> post_cnt_reg == $past(post_cnt_reg) + 4'h1)
      else $error("postscaler did not advance on match");

   // enable register and core gate register
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         irq_enable_reg <= pmt_pkg::IRQ_RESET;
         core_irq_reg <= pmt_pkg::IRQ_RESET;
      end
      else if (bus.wr && (bus.addr == pmt_pkg::ADDR_IRQ_ENABLE))
         irq_enable_reg <= bus.data;
      else if (bus.wr && (bus.addr == pmt_pkg::ADDR_CORE_IRQ))
         core_irq_reg <= bus.data;
   end

   // enable bits are plain storage
   en_write_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      bus.wr && bus.addr == pmt_pkg::ADDR_IRQ_ENABLE |=> irq_enable_reg == $past(bus.data))
      else $error("enable write did not land");

   // sticky flags, cleared by writing one; a new match beats the clear
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
         irq_flags_reg <= pmt_pkg::IRQ_RESET;
      else
      begin
         if (bus.wr && (bus.addr == pmt_pkg::ADDR_IRQ_FLAGS))
            irq_flags_reg <= irq_flags_reg & ~bus.data;
         if (post_fire)
            irq_flags_reg[pmt_pkg::MATCH_BIT] <= 1'b1;
      end
   end

   // flag is set only by the postscaler and cleared only by software
   flag_set_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      post_fire |=> irq_flags_reg[pmt_pkg::MATCH_BIT])
      else $error("match flag not set");
   flag_source_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      $rose(irq_flags_reg[pmt_pkg::MATCH_BIT]) |-> $past(post_fire))
      else $error("match flag set without postscaler");
   flag_hold_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      irq_flags_reg[pmt_pkg::MATCH_BIT] && !(bus.wr && bus.addr == pmt_pkg::ADDR_IRQ_FLAGS)
      |=> irq_flags_reg[pmt_pkg::MATCH_BIT])
      else $error("match flag dropped by itself");
   flag_clear_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      bus.wr && bus.addr == pmt_pkg::ADDR_IRQ_FLAGS && bus.data[pmt_pkg::MATCH_BIT] && !post_fire
      |=> !irq_flags_reg[pmt_pkg::MATCH_BIT])
      else $error("match flag not cleared by write");

   // level interrupt needs flag, enable and both gates
   assign irq_out = irq_flags_reg[pmt_pkg::MATCH_BIT] && irq_enable_reg[pmt_pkg::MATCH_BIT]
                    && core_irq_reg[pmt_pkg::PERIPH_GATE_BIT]
                    && core_irq_reg[pmt_pkg::GLOBAL_GATE_BIT];

   // interrupt is exactly the and of flag, enable and both gates
   irq_gate_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      irq_out |-> irq_flags_reg[pmt_pkg::MATCH_BIT] && irq_enable_reg[pmt_pkg::MATCH_BIT]
         && core_irq_reg[pmt_pkg::PERIPH_GATE_BIT] && core_irq_reg[pmt_pkg::GLOBAL_GATE_BIT])
      else $error("interrupt without flag or gate");
   irq_on_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      irq_flags_reg[pmt_pkg::MATCH_BIT] && irq_enable_reg[pmt_pkg::MATCH_BIT]
         && core_irq_reg[pmt_pkg::PERIPH_GATE_BIT] && core_irq_reg[pmt_pkg::GLOBAL_GATE_BIT] |-> irq_out)
      else $error("interrupt missing with all gates open");

   // read data one cycle after the strobe, zero otherwise or when unmapped
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in || !bus.rd)
         rdata_out <= 8'h00;
      else if (bus.addr == pmt_pkg::ADDR_CONTROL)
         rdata_out <= {1'b0, control_reg};
      else if (bus.addr == pmt_pkg::ADDR_PERIOD)
         rdata_out <= period_reg;
      else if (bus.addr == pmt_pkg::ADDR_COUNT)
         rdata_out <= count_reg;
      else if (bus.addr == pmt_pkg::ADDR_IRQ_ENABLE)
         rdata_out <= irq_enable_reg;
      else if (bus.addr == pmt_pkg::ADDR_IRQ_FLAGS)
         rdata_out <= irq_flags_reg;
      else if (bus.addr == pmt_pkg::ADDR_CORE_IRQ)
         rdata_out <= core_irq_reg;
      else
         rdata_out <= 8'h00;
   end

   // read data carry the register as it stood in the strobe cycle
   ctl_top_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      $past(bus.rd) && $past(bus.addr) == pmt_pkg::ADDR_CONTROL |-> !rdata_out[7])
      else $error("control bit 7 read as one");
   period_read_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      $past(bus.rd) && !$past(sys_rst_in) && $past(bus.addr) == pmt_pkg::ADDR_PERIOD
      |-> rdata_out == $past(period_reg))
      else $error("period read back wrong");
   count_read_a: assert property (
      @(posedge clock_in) disable iff (sys_rst_in)
      $past(bus.rd) && !$past(sys_rst_in) && $past(bus.addr) == pmt_pkg::ADDR_COUNT
      |-> rdata_out == $past(count_reg))
      else $error("count read back wrong");
endmodule : pmt_timer

/* File: verification/tb.sv */
// self-checking bench for the period match timer: registers, scaler ratios, stop, match interrupt
`timescale 1ns/10ps
module tb;
   logic clock_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [3:0] addr_in = 4'h0;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [7:0] rdata_out;
   logic irq_out;
   logic match_pulse_out;
   int error_cnt = 0;
   int n_tests = 0;
   logic [7:0] rv;
   logic [7:0] rv2;
   pmt_timer i_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out), .match_pulse_out(match_pulse_out));
   // 40 MHz clock
   initial
   begin
      forever #12.5 clock_in = ~clock_in;
   end
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // one-cycle write strobe beside address and data
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
      #1;
   endtask : wr
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clock_in);
      rd_in <= 1'b0;
      #1;
      d = rdata_out;
   endtask : rd
   // bounded wait for the next match pulse, returns cycles waited
   task automatic wait_pulse(output int n);
      n = 0;
      do
      begin
         @(posedge clock_in);
         #1;
         n++;
      end
      while (match_pulse_out !== 1'b1 && n < 5000);
   endtask : wait_pulse
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict
   task automatic test_reset_values;
      rd(pmt_pkg::ADDR_CONTROL, rv); chk("control", 16'(rv), 16'h0000);
      rd(pmt_pkg::ADDR_PERIOD, rv); chk("period", 16'(rv), 16'h00FF);
      rd(pmt_pkg::ADDR_COUNT, rv); chk("count", 16'(rv), 16'h0000);
      rd(pmt_pkg::ADDR_IRQ_FLAGS, rv); chk("flags", 16'(rv), 16'h0000);
      chk("irq", 16'(irq_out), 16'h0000);
      $display("test reset values done");
   endtask : test_reset_values
   // stopped timer: control write keeps count, bit 7 reads zero, count holds
   task automatic test_stop_and_rw;
      wr(pmt_pkg::ADDR_PERIOD, 8'hA5);
      rd(pmt_pkg::ADDR_PERIOD, rv); chk("period rw", 16'(rv), 16'h00A5);
      wr(pmt_pkg::ADDR_COUNT, 8'h5A);
      wr(pmt_pkg::ADDR_CONTROL, 8'hFB);
      rd(pmt_pkg::ADDR_CONTROL, rv); chk("control rw", 16'(rv), 16'h007B);
      repeat (40) @(posedge clock_in);
      rd(pmt_pkg::ADDR_COUNT, rv); chk("count held", 16'(rv), 16'h005A);
      rd(4'h3, rv); chk("unmapped", 16'(rv), 16'h0000);
      $display("test stop and access done");
   endtask : test_stop_and_rw
   // interval between match pulses is 4 * prescale ratio (1, 4 or 16 for pre) * (period+1) * (post+1) clocks
   task automatic test_ratio(input logic [1:0] pre, input logic [3:0] post, input logic [7:0] per, input int exp);
      int n;
      wr(pmt_pkg::ADDR_CONTROL, 8'h00);
      wr(pmt_pkg::ADDR_PERIOD, per);
      wr(pmt_pkg::ADDR_COUNT, 8'h00);
      wr(pmt_pkg::ADDR_CONTROL, {1'b0, post, 1'b1, pre});
      wait_pulse(n);
      wait_pulse(n);
      chk("pulse interval", 16'(n), 16'(exp));
      $display("test ratio pre %0d post %0d done", pre, post);
   endtask : test_ratio
   // flag set by the postscaler, gated interrupt, clear by writing one
   task automatic test_irq;
      wr(pmt_pkg::ADDR_CONTROL, 8'h00);
      rd(pmt_pkg::ADDR_IRQ_FLAGS, rv); chk("flag set", 16'(rv), 16'h0002);
      chk("irq no enable", 16'(irq_out), 16'h0000);
      wr(pmt_pkg::ADDR_IRQ_ENABLE, 8'h02);
      wr(pmt_pkg::ADDR_CORE_IRQ, 8'h80);
      chk("irq no periph gate", 16'(irq_out), 16'h0000);
      wr(pmt_pkg::ADDR_CORE_IRQ, 8'h40);
      chk("irq no global gate", 16'(irq_out), 16'h0000);
      wr(pmt_pkg::ADDR_CORE_IRQ, 8'hC0);
      chk("irq on", 16'(irq_out), 16'h0001);
      repeat (20) @(posedge clock_in);
      #1;
      chk("irq sticky", 16'(irq_out), 16'h0001);
      wr(pmt_pkg::ADDR_IRQ_FLAGS, 8'h02);
      chk("irq cleared", 16'(irq_out), 16'h0000);
      rd(pmt_pkg::ADDR_IRQ_FLAGS, rv2); chk("flag cleared", 16'(rv2), 16'h0000);
      $display("test interrupt done");
   endtask : test_irq
   // reset while the timer runs puts period, count and control back to their reset values
   task automatic test_mid_reset;
      wr(pmt_pkg::ADDR_PERIOD, 8'h33);
      wr(pmt_pkg::ADDR_CONTROL, 8'h04);
      repeat (30) @(posedge clock_in);
      sys_rst_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      rd(pmt_pkg::ADDR_PERIOD, rv); chk("period after reset", 16'(rv), 16'h00FF);
      rd(pmt_pkg::ADDR_COUNT, rv); chk("count after reset", 16'(rv), 16'h0000);
      rd(pmt_pkg::ADDR_CONTROL, rv); chk("control after reset", 16'(rv), 16'h0000);
      $display("test mid-run reset done");
   endtask : test_mid_reset
   // hang guard, tests take under 8000 cycles
   initial
   begin
      #(25 * 40000);
      error_cnt++;
      give_verdict();
   end
   initial
   begin
      repeat (10) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      test_reset_values();
      test_stop_and_rw();
      test_ratio(2'h0, 4'h0, 8'h03, 16);
      test_ratio(2'h1, 4'h1, 8'h02, 96);
      test_ratio(2'h2, 4'hF, 8'h01, 2048);
      test_ratio(2'h3, 4'h2, 8'h00, 192);
      test_irq();
      test_mid_reset();
      give_verdict();
   end
endmodule : tb
